/* hdl/cfgopt_top.sv */
// configuration option registers with apb access and shared pin ownership
//
// Overview of operation
// - after any reset all pins plain input
// - pins 0,1: analog, timer, keyboard, port
// - pin 2: interrupt, keyboard, timer clock, port
// - pin 3: reset, keyboard, port
// - pins 4,5: oscillator, analog, keyboard, port
// - pullup disable bit set disconnects pullup
// - interrupt function bit set activates pin function
// - two option bits choose clock source
// - reset function bit set activates pin reset
// - only power-on reset clears reset function bit
// - period bit picks watchdog timeout outside stop
// - period bit picks wakeup interval in stop
// - stop enable keeps detector running in stop, unless powered down; reset clears
// - reset disable bit suppresses detector resets
`timescale 1ns/100ps
`include "cfgopt_consts.svh"

module cfgopt_top #(
   parameter int ADDR_W = 8 // apb address width
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic other_reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic stop_mode,
   input wire logic [3:0] analog_en,
   input wire logic [1:0] timer_ch_en,
   input wire logic [5:0] kbi_en,
   input wire logic timer_ext_clock_en,
   input wire logic lvd_trip_raw,
   output cfgopt_pkg::cfgopt_owner_t [5:0] pin_owner,
   output logic intpin_pullup_on,
   output logic intpin_active,
   output cfgopt_pkg::cfgopt_osc_t clock_source,
   output logic resetpin_active,
   output logic watchdog_enabled,
   output logic [`CFGOPT_WDOG_W-1:0] watchdog_timeout,
   output logic [`CFGOPT_AWU_W-1:0] wakeup_interval,
   output logic lvd_enable,
   output logic lvd_reset_out,
   output logic lowvolt_trip_select,
   output logic short_stop_recovery,
   output logic stop_allowed
);
   import cfgopt_pkg::*;

   cfgopt_state_t s_reg; // registered state
   cfgopt_state_t s_next; // next state
   cfgopt_pin_if pin (); // carrier to the resolver

   // byte address of a register from its index
   function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
      input logic [7:0] idx);
      logic [ADDR_W-1:0] want;
      want = ADDR_W'({idx, 2'b00});
      return (a == want);
   endfunction

   // short names for the stored option bits
   logic [7:0] c1; // option_control_one
   logic [7:0] c2; // option_control_two
   assign c1 = s_reg.cfg_one;
   assign c2 = s_reg.cfg_two;

   // apb phase decode
   logic access_ph; // access phase, answer pending or given
   logic complete; // transfer completes at this edge
   logic hit_one; // address matches option_control_one
   logic hit_two; // address matches option_control_two
   assign access_ph = psel && penable;
   assign complete = access_ph && s_reg.pready;
   assign hit_one = addr_hit(paddr, `CFGOPT_IDX_ONE);
   assign hit_two = addr_hit(paddr, `CFGOPT_IDX_TWO);

   // requests handed to the resolver
   assign pin.released = s_reg.released;
   assign pin.analog_req = analog_en;
   assign pin.timer_req = timer_ch_en;
   assign pin.kbi_req = kbi_en;
   assign pin.ext_clock_req = timer_ext_clock_en;
   assign pin.intpin_req = c2[`CFGOPT_B2_INT_EN];
   assign pin.resetpin_req = c2[`CFGOPT_B2_RST_EN];
   // external clock and rc use pin 5; the crystal needs both
   assign pin.osc_one_req = (c2[`CFGOPT_B2_OSC_HI] || c2[`CFGOPT_B2_OSC_LO]);
   assign pin.osc_two_req = (c2[`CFGOPT_B2_OSC_HI] && c2[`CFGOPT_B2_OSC_LO]);

   // priority resolver; its answer is registered below
   cfgopt_pinmux u_pinmux (
      .pin(pin)
   );

   // next state: bus, other reset, detector sync, outputs
   always_comb begin
      s_next = s_reg;

      // apb answer comes one cycle into the access phase
      if (access_ph && !s_reg.pready) begin
         s_next.pready = 1'b1;
         s_next.pslverr = !(hit_one || hit_two);
         if (hit_one) begin
            s_next.prdata = {24'h000000, c1};
         end else if (hit_two) begin
            s_next.prdata = {24'h000000, c2};
         end else begin
            s_next.prdata = 32'h00000000;
         end
      end else begin
         // answer stands for exactly one cycle
         s_next.pready = 1'b0;
         s_next.pslverr = 1'b0;
      end

      // writes take effect only at the completing edge
      if (complete && pwrite && hit_one) begin
         s_next.cfg_one = pwdata[7:0];
         s_next.released = 1'b1;
      end
      if (complete && pwrite && hit_two) begin
         // unused bit positions stay zero
         s_next.cfg_two = pwdata[7:0] & `CFGOPT_WMASK_TWO;
         s_next.released = 1'b1;
      end

      // any reset other than power-on; it wins over a write
      if (other_reset) begin
         s_next.cfg_one = s_reg.cfg_one & `CFGOPT_KEEP_ONE;
         s_next.cfg_two = s_reg.cfg_two & `CFGOPT_KEEP_TWO;
         s_next.released = 1'b0;
      end

      // three stages for the asynchronous detector level
      s_next.lvd_sync = {s_reg.lvd_sync[1:0], lvd_trip_raw};
      // a change counts once the second and third stage agree
      if (s_reg.lvd_sync[1] == s_reg.lvd_sync[2]) begin
         s_next.lvd_level = s_reg.lvd_sync[2];
      end

      // registered pin ownership; forced to port during reset
      if (other_reset) begin
         // element by element, so each pin keeps its enum type
         for (int k = 0; k < 6; k++) begin
            s_next.owner[k] = OWN_GPIO;
         end
      end else begin
         s_next.owner = pin.owner;
      end

      // pin options
      s_next.pullup_on = !c2[`CFGOPT_B2_PULL_DIS];
      s_next.intpin_active = c2[`CFGOPT_B2_INT_EN];
      s_next.clk_src = cfgopt_osc_t'({c2[`CFGOPT_B2_OSC_HI],
         c2[`CFGOPT_B2_OSC_LO]});
      s_next.resetpin_active = c2[`CFGOPT_B2_RST_EN];

      // watchdog timeout only outside stop, wakeup interval only inside it; the watchdog enable ignores stop
      s_next.wdog_en = !c1[`CFGOPT_B1_WDOG_DIS];
      if (!stop_mode) begin
         s_next.wdog_timeout = c1[`CFGOPT_B1_PERIOD] ?
            `CFGOPT_WDOG_SHORT : `CFGOPT_WDOG_LONG;
         s_next.wake_interval = '0;
      end else begin
         s_next.wdog_timeout = '0;
         s_next.wake_interval = c1[`CFGOPT_B1_PERIOD] ?
            `CFGOPT_AWU_SHORT : `CFGOPT_AWU_LONG;
      end

      // detector powered unless powered down; in stop only if enabled
      s_next.lvd_enable = !c1[`CFGOPT_B1_LV_PWRDN] &&
         (!stop_mode || c1[`CFGOPT_B1_LV_STOPEN]);
      // detector reset passes only when not disabled
      s_next.lvd_reset = s_reg.lvd_level &&
         !c1[`CFGOPT_B1_LV_RSTDIS];

      // remaining plain option bits
      s_next.trip_high = c1[`CFGOPT_B1_LV_TRIP];
      s_next.short_recovery = c1[`CFGOPT_B1_SHORT_REC];
      s_next.stop_allowed = c1[`CFGOPT_B1_STOP_OK];
   end

   // state register; presetn is the power-on reset and clears all
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_reg <= CFGOPT_STATE_POR;
      end else begin
         s_reg <= s_next;
      end
   end

   // every output straight from the state register
   assign prdata = s_reg.prdata;
   assign pready = s_reg.pready;
   assign pslverr = s_reg.pslverr;
   assign pin_owner = s_reg.owner;
   assign intpin_pullup_on = s_reg.pullup_on;
   assign intpin_active = s_reg.intpin_active;
   assign clock_source = s_reg.clk_src;
   assign resetpin_active = s_reg.resetpin_active;
   assign watchdog_enabled = s_reg.wdog_en;
   assign watchdog_timeout = s_reg.wdog_timeout;
   assign wakeup_interval = s_reg.wake_interval;
   assign lvd_enable = s_reg.lvd_enable;
   assign lvd_reset_out = s_reg.lvd_reset;
   assign lowvolt_trip_select = s_reg.trip_high;
   assign short_stop_recovery = s_reg.short_recovery;
   assign stop_allowed = s_reg.stop_allowed;
endmodule

/* hdl/cfgopt_consts.svh */
// named constants for the configuration option and pin priority block
`ifndef CFGOPT_CONSTS_SVH
`define CFGOPT_CONSTS_SVH

// register indices; byte address is four times the index
`define CFGOPT_IDX_ONE 8'h1F
`define CFGOPT_IDX_TWO 8'h1E

// option_control_one field positions
`define CFGOPT_B1_PERIOD 7
`define CFGOPT_B1_LV_STOPEN 6
`define CFGOPT_B1_LV_RSTDIS 5
`define CFGOPT_B1_LV_PWRDN 4
`define CFGOPT_B1_LV_TRIP 3
`define CFGOPT_B1_SHORT_REC 2
`define CFGOPT_B1_STOP_OK 1
`define CFGOPT_B1_WDOG_DIS 0

// option_control_two field positions
`define CFGOPT_B2_PULL_DIS 7
`define CFGOPT_B2_INT_EN 6
`define CFGOPT_B2_OSC_HI 4
`define CFGOPT_B2_OSC_LO 3
`define CFGOPT_B2_RST_EN 0

// power-on values, bits kept through any other reset, and writable bits of option_control_two
`define CFGOPT_POR_ONE 8'h00
`define CFGOPT_POR_TWO 8'h00
`define CFGOPT_KEEP_ONE 8'h08
`define CFGOPT_KEEP_TWO 8'h01
`define CFGOPT_WMASK_TWO 8'hD9

// watchdog and wakeup periods, in cycles of their own clocks
`define CFGOPT_WDOG_W 18
`define CFGOPT_AWU_W 15
`define CFGOPT_WDOG_SHORT 18'h01FF0
`define CFGOPT_WDOG_LONG 18'h3FFF0
`define CFGOPT_AWU_SHORT 15'h0200
`define CFGOPT_AWU_LONG 15'h4000

`endif

/* hdl/cfgopt_pkg.sv */
// types for the configuration option and pin priority block
`include "cfgopt_consts.svh"

package cfgopt_pkg;

   // function that owns a shared pin; first entry is plain port
   typedef enum logic [2:0] {
      OWN_GPIO,
      OWN_ANALOG,
      OWN_TIMER,
      OWN_KEYBOARD,
      OWN_INTPIN,
      OWN_EXT_CLOCK,
      OWN_RESET,
      OWN_OSC
   } cfgopt_owner_t;

   // clock source, in the order of the two option bits
   typedef enum logic [1:0] {
      OSC_INTERNAL,
      OSC_EXTERNAL,
      OSC_EXT_RC,
      OSC_EXT_XTAL
   } cfgopt_osc_t;

   // whole state of the top module
   typedef struct packed {
      logic [7:0] cfg_one;
      logic [7:0] cfg_two;
      logic released;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic [2:0] lvd_sync;
      logic lvd_level;
      cfgopt_owner_t [5:0] owner;
      logic pullup_on;
      logic intpin_active;
      cfgopt_osc_t clk_src;
      logic resetpin_active;
      logic wdog_en;
      logic [`CFGOPT_WDOG_W-1:0] wdog_timeout;
      logic [`CFGOPT_AWU_W-1:0] wake_interval;
      logic lvd_enable;
      logic lvd_reset;
      logic trip_high;
      logic short_recovery;
      logic stop_allowed;
   } cfgopt_state_t;

   // power-on value of the whole state
   localparam cfgopt_state_t CFGOPT_STATE_POR = '0;

endpackage

/* hdl/cfgopt_pin_if.sv */
// carrier between the option registers and the pin priority resolver
`timescale 1ns/100ps

interface cfgopt_pin_if;
   import cfgopt_pkg::*;
   logic released; // alternate functions allowed after reset
   logic [3:0] analog_req; // analog channel enables
   logic [1:0] timer_req; // timer channel enables
   logic [5:0] kbi_req; // keyboard input enables
   logic ext_clock_req; // timer external clock enable
   logic intpin_req; // interrupt request function on
   logic resetpin_req; // reset function on
   logic osc_one_req; // oscillator uses pin 5
   logic osc_two_req; // oscillator uses pin 4
   cfgopt_owner_t [5:0] owner; // resolved owner per pin

   modport cfg (output released, analog_req, timer_req, kbi_req, ext_clock_req,
      intpin_req, resetpin_req, osc_one_req, osc_two_req, input owner);
   modport mux (input released, analog_req, timer_req, kbi_req, ext_clock_req,
      intpin_req, resetpin_req, osc_one_req, osc_two_req, output owner);
endinterface

/* hdl/cfgopt_pinmux.sv */
// pin priority resolver for the six shared port pins
`timescale 1ns/100ps

module cfgopt_pinmux (
   cfgopt_pin_if.mux pin
);
   import cfgopt_pkg::*;

   // three-level priority ahead of the plain port
   function automatic cfgopt_owner_t resolve(
      input logic hi_en, input cfgopt_owner_t hi_own,
      input logic mid_en, input cfgopt_owner_t mid_own,
      input logic lo_en, input cfgopt_owner_t lo_own);
      cfgopt_owner_t r;
      if (hi_en) begin
         r = hi_own;
      end else if (mid_en) begin
         r = mid_own;
      end else if (lo_en) begin
         r = lo_own;
      end else begin
         r = OWN_GPIO;
      end
      return r;
   endfunction

   // pins 0 and 1 share one pattern
   genvar i;
   generate
      for (i = 0; i < 2; i = i + 1) begin : g_low
         // held as plain input until released after reset
         assign pin.owner[i] = !pin.released ? OWN_GPIO :
            resolve(pin.analog_req[i], OWN_ANALOG, pin.timer_req[i], OWN_TIMER,
               pin.kbi_req[i], OWN_KEYBOARD);
      end
   endgenerate

   // pin 2: interrupt, keyboard, timer clock
   assign pin.owner[2] = !pin.released ? OWN_GPIO :
      resolve(pin.intpin_req, OWN_INTPIN, pin.kbi_req[2], OWN_KEYBOARD,
         pin.ext_clock_req, OWN_EXT_CLOCK);

   // pin 3: reset, keyboard; no third level
   assign pin.owner[3] = !pin.released ? OWN_GPIO :
      resolve(pin.resetpin_req, OWN_RESET, pin.kbi_req[3], OWN_KEYBOARD,
         1'b0, OWN_GPIO);

   // pins 4 and 5: oscillator, analog, keyboard
   assign pin.owner[4] = !pin.released ? OWN_GPIO :
      resolve(pin.osc_two_req, OWN_OSC, pin.analog_req[2], OWN_ANALOG,
         pin.kbi_req[4], OWN_KEYBOARD);
   assign pin.owner[5] = !pin.released ? OWN_GPIO :
      resolve(pin.osc_one_req, OWN_OSC, pin.analog_req[3], OWN_ANALOG,
         pin.kbi_req[5], OWN_KEYBOARD);
endmodule

/* bench/cfgopt_checker.sv */
// concurrent checks on the option register ports and pin ownership
`timescale 1ns/100ps
`include "cfgopt_consts.svh"

module cfgopt_checker #(
   parameter int ADDR_W = 8 // apb address width
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic other_reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic stop_mode,
   input wire cfgopt_pkg::cfgopt_owner_t [5:0] pin_owner,
   input wire logic intpin_pullup_on,
   input wire cfgopt_pkg::cfgopt_osc_t clock_source,
   input wire logic [`CFGOPT_WDOG_W-1:0] watchdog_timeout,
   input wire logic [`CFGOPT_AWU_W-1:0] wakeup_interval
);
   import cfgopt_pkg::*;
   // completed transfers and their decoded target
   wire logic done = psel && penable && pready;
   wire logic hit_one = paddr == ADDR_W'(`CFGOPT_IDX_ONE * 4);
   wire logic hit_two = paddr == ADDR_W'(`CFGOPT_IDX_TWO * 4);
   wire logic wr_one = done && pwrite && hit_one;
   wire logic wr_two = done && pwrite && hit_two;
   // a soft reset abandons pending write checks, so it disables them too
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn || other_reset);

   wait_state_a: assert property (psel && !penable |=> !pready ##1 pready)
      else $error("answer not after exactly one wait state");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("error flag outside the answer cycle");
   unmapped_err_a: assert property (done && !hit_one && !hit_two |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   pullup_ctl_a: assert property (
      wr_two |-> ##2 intpin_pullup_on == !$past(pwdata[`CFGOPT_B2_PULL_DIS], 2))
      else $error("pullup does not follow its control bit");
   osc_sel_a: assert property (
      wr_two |-> ##2 clock_source == $past(pwdata[`CFGOPT_B2_OSC_HI:`CFGOPT_B2_OSC_LO], 2))
      else $error("clock source does not follow option bits");
   wdog_period_a: assert property (
      wr_one ##1 !stop_mode ##1 !stop_mode |-> watchdog_timeout ==
      ($past(pwdata[`CFGOPT_B1_PERIOD], 2) ? `CFGOPT_WDOG_SHORT : `CFGOPT_WDOG_LONG))
      else $error("watchdog timeout wrong");
   awu_period_a: assert property (
      wr_one ##1 stop_mode ##1 stop_mode |-> wakeup_interval ==
      ($past(pwdata[`CFGOPT_B1_PERIOD], 2) ? `CFGOPT_AWU_SHORT : `CFGOPT_AWU_LONG))
      else $error("wakeup interval wrong");
   gpio_lock_a: assert property (
      disable iff (!presetn) other_reset |=> (pin_owner == '0) [*2])
      else $error("pins not plain input after reset");
endmodule

bind cfgopt_top cfgopt_checker #(.ADDR_W(ADDR_W)) chk (.*);

/* bench/tb_top.sv */
// self-checking bench for the option registers and pin ownership
`timescale 1ns/100ps
`include "cfgopt_consts.svh"

module tb_top;
   import cfgopt_pkg::*;
   // one row: pin requests, option_control_two value, owners pin5..pin0
   typedef struct {
      logic [3:0] an;
      logic [1:0] tm;
      logic [5:0] kb;
      logic tc;
      logic [7:0] c2;
      logic [17:0] own;
   } cfgopt_row_t;
   cfgopt_row_t rows[7] = '{
      '{4'h0, 2'h0, 6'h00, 1'b0, 8'h80, 18'h00000},
      '{4'hF, 2'h3, 6'h3F, 1'b1, 8'h00, 18'h096C9},
      '{4'h0, 2'h3, 6'h3F, 1'b1, 8'h00, 18'h1B6D2},
      '{4'h0, 2'h0, 6'h00, 1'b1, 8'h00, 18'h00140},
      '{4'hF, 2'h3, 6'h3F, 1'b1, 8'hFF, 18'h3FD09},
      '{4'hF, 2'h0, 6'h3F, 1'b0, 8'h08, 18'h396C9},
      '{4'hF, 2'h0, 6'h00, 1'b0, 8'h10, 18'h39009}};
   logic pclk, presetn, other_reset, psel, penable, pwrite, pready, pslverr, er;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic stop_mode, timer_ext_clock_en, lvd_trip_raw;
   logic [3:0] analog_en;
   logic [1:0] timer_ch_en;
   logic [5:0] kbi_en;
   cfgopt_owner_t [5:0] pin_owner;
   cfgopt_osc_t clock_source;
   logic intpin_pullup_on, intpin_active, resetpin_active, watchdog_enabled;
   logic [`CFGOPT_WDOG_W-1:0] watchdog_timeout;
   logic [`CFGOPT_AWU_W-1:0] wakeup_interval;
   logic lvd_enable, lvd_reset_out, lowvolt_trip_select, short_stop_recovery, stop_allowed;
   int n_errors = 0;
   int total_checks = 0;

   cfgopt_top #(.ADDR_W(8)) DUT (.*);

   // free-running bus clock, 8 ns
   always #4 pclk = ~pclk;

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // one apb transfer; the extra edge at the end keeps strobes from double assignment
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // no cap here: a missing answer is left to the watchdog
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // option_control_one write, then the derived outputs
   task automatic opt1(input logic [7:0] v, input logic s, input logic [17:0] to,
      input logic [14:0] wu, input logic lv);
      stop_mode <= s;
      apb(1'b1, 8'h7C, {24'h0, v}, rd, er);
      repeat (3) @(posedge pclk);
      check("watchdog_timeout", 32'(watchdog_timeout), 32'(to));
      check("wakeup_interval", 32'(wakeup_interval), 32'(wu));
      check("lvd_enable", 32'(lvd_enable), 32'(lv));
      check("watchdog_enabled", 32'(watchdog_enabled), 32'(!v[0]));
      check("opt1 flags", 32'({lowvolt_trip_select, short_stop_recovery, stop_allowed}),
         32'(v[3:1]));
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // watchdog: the whole run needs well under two thousand cycles
   initial begin
      #50000;
      n_errors++;
      report_and_stop();
   end

   initial begin
      {pclk, presetn, other_reset, psel, penable, pwrite, stop_mode} = '0;
      {timer_ext_clock_en, lvd_trip_raw, analog_en, timer_ch_en, kbi_en, paddr, pwdata} = '0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // priority table, also covering every oscillator code
      foreach (rows[i]) begin
         analog_en <= rows[i].an;
         timer_ch_en <= rows[i].tm;
         kbi_en <= rows[i].kb;
         timer_ext_clock_en <= rows[i].tc;
         apb(1'b1, 8'h78, {24'h0, rows[i].c2}, rd, er);
         apb(1'b0, 8'h78, 32'h0, rd, er);
         check("option_control_two", rd, {24'h0, rows[i].c2 & `CFGOPT_WMASK_TWO});
         check("pin_owner", 32'(pin_owner), 32'(rows[i].own));
         check("intpin_pullup_on", 32'(intpin_pullup_on), 32'(!rows[i].c2[7]));
         check("intpin_active", 32'(intpin_active), 32'(rows[i].c2[6]));
         check("clock_source", 32'(clock_source), 32'(rows[i].c2[4:3]));
         check("resetpin_active", 32'(resetpin_active), 32'(rows[i].c2[0]));
      end
      $display("pin table done");
      opt1(8'hFF, 1'b0, 18'h01FF0, 15'h0, 1'b0);
      opt1(8'hFF, 1'b1, 18'h0, 15'h0200, 1'b0);
      opt1(8'h00, 1'b1, 18'h0, 15'h4000, 1'b0);
      opt1(8'h40, 1'b1, 18'h0, 15'h4000, 1'b1);
      opt1(8'h00, 1'b0, 18'h3FFF0, 15'h0, 1'b1);
      // detector reset issued, then suppressed by the disable bit
      lvd_trip_raw <= 1'b1;
      repeat (8) @(posedge pclk);
      check("lvd_reset_out", 32'(lvd_reset_out), 32'h1);
      apb(1'b1, 8'h7C, 32'h20, rd, er);
      repeat (3) @(posedge pclk);
      check("lvd_reset_out", 32'(lvd_reset_out), 32'h0);
      lvd_trip_raw <= 1'b0;
      $display("option one done");
      // soft reset keeps the reset-pin bit, power-on reset clears it
      apb(1'b1, 8'h78, 32'h01, rd, er);
      apb(1'b1, 8'h7C, 32'h48, rd, er);
      other_reset <= 1'b1;
      @(posedge pclk);
      other_reset <= 1'b0;
      repeat (3) @(posedge pclk);
      check("pin_owner", 32'(pin_owner), 32'h0);
      check("resetpin_active", 32'(resetpin_active), 32'h1);
      apb(1'b0, 8'h7C, 32'h0, rd, er);
      check("option_control_one", rd, 32'h08);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      check("resetpin_active", 32'(resetpin_active), 32'h0);
      check("pin_owner", 32'(pin_owner), 32'h0);
      check("intpin_pullup_on", 32'(intpin_pullup_on), 32'h1);
      check("clock_source", 32'(clock_source), 32'h0);
      check("watchdog_timeout", 32'(watchdog_timeout), 32'(`CFGOPT_WDOG_LONG));
      check("lvd_enable", 32'(lvd_enable), 32'h1);
      apb(1'b0, 8'h7C, 32'h0, rd, er);
      check("option_control_one", rd, 32'h0);
      apb(1'b0, 8'h78, 32'h0, rd, er);
      check("option_control_two", rd, 32'h0);
      apb(1'b0, 8'h00, 32'h0, rd, er);
      check("pslverr", 32'(er), 32'h1);
      check("prdata", rd, 32'h0);
      $display("reset and refusal done");
      report_and_stop();
   end
endmodule
